/* File: reconfig_consts.svh */
`ifndef RECONFIG_CONSTS_SVH
`define RECONFIG_CONSTS_SVH

`define ADDR_W 9
`define DATA_W 16
`define CLOCK_MHZ 125
// busy cycles between accepting a request and the done strobe
`define ACCESS_LATENCY 4'h3
`define RESET_SEQ_NS 1000
`define RESET_SEQ_CYCLES ((`RESET_SEQ_NS * `CLOCK_MHZ + 999) / 1000)
`define QUARTER_DIV 4
`define READ_WORD_RESET 16'h0000
`define DONE_RESET 1'b0
`define BUSY_RESET 1'b0
`define PMA_RESET_RESET 1'b1

`endif

/* File: reconfig_pkg.sv */
`include "reconfig_consts.svh"
package reconfig_pkg;
  typedef logic [`ADDR_W-1:0] addr_t;
  typedef logic [`DATA_W-1:0] word_t;
  typedef enum logic [1:0] {dev_idle, dev_busy} dev_state_e;
  typedef enum logic [1:0] {host_idle, host_issue, host_wait} host_state_e;
endpackage

/* File: reconfig_if.sv */
`timescale 1ns/1ns
interface reconfig_if;
  import reconfig_pkg::*;
  logic reconfig_access_strobe_alias;
  logic reconfig_write_select;
  addr_t reconfig_reg_address;
  word_t reconfig_write_word;
  word_t reconfig_read_word;
  logic reconfig_done_strobe;
  logic reconfig_port_busy;

  modport device (
    input reconfig_access_strobe_alias,
    input reconfig_write_select,
    input reconfig_reg_address,
    input reconfig_write_word,
    output reconfig_read_word,
    output reconfig_done_strobe,
    output reconfig_port_busy
  );

  modport requester (
    output reconfig_access_strobe_alias,
    output reconfig_write_select,
    output reconfig_reg_address,
    output reconfig_write_word,
    input reconfig_read_word,
    input reconfig_done_strobe,
    input reconfig_port_busy
  );
endinterface

/* File: reconfig_device.sv */
`timescale 1ns/1ns
module reconfig_device #(
  parameter bit CSP_ENABLE = 1'b1
) (
  input wire logic clock,
  input wire logic rst,
  reconfig_if.device port,
  input wire logic hard_reset_pin,
  output logic reset_done,
  output logic pma_reset_out,
  output logic stable_clock_quarter
);
  import reconfig_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // configuration space and access engine

  word_t cfg_mem [0:(1 << `ADDR_W) - 1];

  dev_state_e state_r, state_nxt;
  logic [3:0] lat_r, lat_nxt;
  addr_t addr_r, addr_nxt;
  word_t wword_r, wword_nxt;
  logic write_r, write_nxt;
  word_t read_word_r, read_word_nxt;
  logic done_r, done_nxt;
  logic busy_r, busy_nxt;
  logic commit;

  always_comb begin
    state_nxt = state_r;
    lat_nxt = lat_r;
    addr_nxt = addr_r;
    wword_nxt = wword_r;
    write_nxt = write_r;
    read_word_nxt = read_word_r;
    done_nxt = 1'b0;
    busy_nxt = busy_r;
    commit = 1'b0;
    case (state_r)
      dev_idle: begin
        // a strobe while busy is dropped; the requester must wait for done
        if (CSP_ENABLE && port.reconfig_access_strobe_alias) begin
          addr_nxt = port.reconfig_reg_address;
          wword_nxt = port.reconfig_write_word;
          write_nxt = port.reconfig_write_select;
          lat_nxt = `ACCESS_LATENCY;
          busy_nxt = 1'b1;
          state_nxt = dev_busy;
        end
      end
      dev_busy: begin
        lat_nxt = lat_r - 4'h1;
        if (lat_r == 4'h1) begin
          commit = 1'b1;
          done_nxt = 1'b1;
          busy_nxt = 1'b0;
          state_nxt = dev_idle;
          if (!write_r) begin
            read_word_nxt = cfg_mem[addr_r];
          end
        end
      end
      default: begin
        state_nxt = dev_idle;
        busy_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= dev_idle;
      lat_r <= 4'h0;
      addr_r <= '0;
      wword_r <= '0;
      write_r <= 1'b0;
      read_word_r <= `READ_WORD_RESET;
      done_r <= `DONE_RESET;
      busy_r <= `BUSY_RESET;
    end else begin
      state_r <= state_nxt;
      lat_r <= lat_nxt;
      addr_r <= addr_nxt;
      wword_r <= wword_nxt;
      write_r <= write_nxt;
      read_word_r <= read_word_nxt;
      done_r <= done_nxt;
      busy_r <= busy_nxt;
    end
  end

  // memory has no reset; unwritten words read back undefined
  always_ff @(posedge clock) begin
    if (commit && write_r) begin
      cfg_mem[addr_r] <= wword_r;
    end
  end

  assign port.reconfig_read_word = read_word_r;
  assign port.reconfig_done_strobe = done_r;
  assign port.reconfig_port_busy = busy_r;

  ////////////////////////////////////////////////////////////////////////////
  // transceiver reset sequence

  localparam int SEQ_CYCLES = `RESET_SEQ_CYCLES;
  logic [11:0] seq_cnt_r, seq_cnt_nxt;
  logic reset_done_r, reset_done_nxt;
  // the synchronised hard reset, registered in the synchroniser below
  logic pma_reset_r, pma_reset_nxt;

  always_comb begin
    seq_cnt_nxt = seq_cnt_r;
    reset_done_nxt = reset_done_r;
    // the sequence restarts whenever the hard reset is asserted
    if (pma_reset_r) begin
      seq_cnt_nxt = 12'h000;
      reset_done_nxt = 1'b0;
    end else if (seq_cnt_r == 12'(SEQ_CYCLES - 1)) begin
      reset_done_nxt = 1'b1;
    end else begin
      seq_cnt_nxt = seq_cnt_r + 12'h001;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      seq_cnt_r <= 12'h000;
      reset_done_r <= 1'b0;
    end else begin
      seq_cnt_r <= seq_cnt_nxt;
      reset_done_r <= reset_done_nxt;
    end
  end

  assign reset_done = reset_done_r;

  ////////////////////////////////////////////////////////////////////////////
  // hard reset synchroniser

  // the third flop only confirms that the second has settled; the extra
  // latency costs nothing, as the reset sequence runs far longer
  logic sync1_r, sync2_r, sync3_r;

  always_comb begin
    pma_reset_nxt = pma_reset_r;
    // only a settled value passes, so a glitch on the pin is not seen
    if (sync2_r == sync3_r) begin
      pma_reset_nxt = sync3_r;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
      pma_reset_r <= `PMA_RESET_RESET;
    end else begin
      sync1_r <= hard_reset_pin;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      pma_reset_r <= pma_reset_nxt;
    end
  end

  assign pma_reset_out = pma_reset_r;

  ////////////////////////////////////////////////////////////////////////////
  // quarter-rate stable clock, driven only when CSP_ENABLE is clear (held low otherwise)

  logic [1:0] div_r, div_nxt;
  logic quarter_r, quarter_nxt;

  always_comb begin
    div_nxt = div_r + 2'h1;
    quarter_nxt = 1'b0;
    if (!CSP_ENABLE) begin
      quarter_nxt = (div_r < 2'(`QUARTER_DIV / 2));
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      div_r <= 2'h0;
      quarter_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      quarter_r <= quarter_nxt;
    end
  end

  assign stable_clock_quarter = quarter_r;
endmodule

/* File: reconfig_requester.sv */
`timescale 1ns/1ns
module reconfig_requester (
  input wire logic clock,
  input wire logic rst,
  reconfig_if.requester port,
  input wire logic req_valid,
  input wire logic req_write,
  input wire reconfig_pkg::addr_t req_addr,
  input wire reconfig_pkg::word_t req_wdata,
  output logic req_ready,
  output logic resp_valid,
  output reconfig_pkg::word_t resp_data
);
  import reconfig_pkg::*;

  ////////////////////////////////////////////////////////////////////////////

  host_state_e state_r, state_nxt;
  logic strobe_r, strobe_nxt;
  logic we_r, we_nxt;
  addr_t addr_r, addr_nxt;
  word_t wdata_r, wdata_nxt;
  logic ready_r, ready_nxt;
  logic resp_valid_r, resp_valid_nxt;
  word_t resp_data_r, resp_data_nxt;

  always_comb begin
    state_nxt = state_r;
    strobe_nxt = 1'b0;
    we_nxt = we_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    ready_nxt = ready_r;
    resp_valid_nxt = 1'b0;
    resp_data_nxt = resp_data_r;
    case (state_r)
      host_idle: begin
        ready_nxt = !port.reconfig_port_busy;
        if (req_valid && ready_r && !port.reconfig_port_busy) begin
          strobe_nxt = 1'b1;
          we_nxt = req_write;
          addr_nxt = req_addr;
          wdata_nxt = req_wdata;
          ready_nxt = 1'b0;
          state_nxt = host_issue;
        end
      end
      host_issue: begin
        state_nxt = host_wait;
      end
      host_wait: begin
        // no timeout: a device that never answers stalls the requester
        if (port.reconfig_done_strobe) begin
          resp_valid_nxt = 1'b1;
          resp_data_nxt = we_r ? 16'h0000 : port.reconfig_read_word;
          ready_nxt = 1'b1;
          state_nxt = host_idle;
        end
      end
      default: begin
        state_nxt = host_idle;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= host_idle;
      strobe_r <= 1'b0;
      we_r <= 1'b0;
      addr_r <= '0;
      wdata_r <= '0;
      ready_r <= 1'b0;
      resp_valid_r <= 1'b0;
      resp_data_r <= '0;
    end else begin
      state_r <= state_nxt;
      strobe_r <= strobe_nxt;
      we_r <= we_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      ready_r <= ready_nxt;
      resp_valid_r <= resp_valid_nxt;
      resp_data_r <= resp_data_nxt;
    end
  end

  assign port.reconfig_access_strobe_alias = strobe_r;
  assign port.reconfig_write_select = we_r;
  assign port.reconfig_reg_address = addr_r;
  assign port.reconfig_write_word = wdata_r;
  assign req_ready = ready_r;
  assign resp_valid = resp_valid_r;
  assign resp_data = resp_data_r;
endmodule

/* File: reconfig_port_properties.sv */
`timescale 1ns/1ns
module reconfig_port_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic reconfig_access_strobe_alias,
  input wire logic reconfig_write_select,
  input wire reconfig_pkg::addr_t reconfig_reg_address,
  input wire reconfig_pkg::word_t reconfig_write_word,
  input wire reconfig_pkg::word_t reconfig_read_word,
  input wire logic reconfig_done_strobe,
  input wire logic reconfig_port_busy
);
  import reconfig_pkg::*;
  wire stb = reconfig_access_strobe_alias;
  wire busy = reconfig_port_busy;
  wire done = reconfig_done_strobe;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  sequence s_take; stb && !busy; endsequence
  sequence s_serve; busy [*3] ##1 (done && !busy); endsequence
  property p_latency; s_take |=> s_serve; endproperty
  property p_idle; !stb && !busy |=> !busy; endproperty
  property p_pulse; stb |=> !stb; endproperty
  property p_wait_busy; busy |-> !stb; endproperty
  property p_done_pulse; done |=> !done; endproperty
  property p_hold; !done |-> $stable(reconfig_read_word); endproperty
  // the past-reset guard keeps a short reset from faking a busy edge
  property p_done_end; !$past(rst) && $fell(busy) |-> done; endproperty
  property p_gap; done |-> !stb; endproperty
  a_latency: assert property (p_latency) else $error("done late or early");
  a_idle: assert property (p_idle) else $error("busy without request");
  a_pulse: assert property (p_pulse) else $error("strobe longer than one cycle");
  a_wait_busy: assert property (p_wait_busy) else $error("strobe while busy");
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
  a_hold: assert property (p_hold) else $error("read word moved without done");
  a_done_end: assert property (p_done_end) else $error("busy ended without done");
  a_gap: assert property (p_gap) else $error("strobe in the done cycle");
endmodule

/* File: transceiver_reconfig_status_port_test.sv */
`timescale 1ns/1ns
`include "reconfig_consts.svh"
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin errors++; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module transceiver_reconfig_status_port_test;
  import reconfig_pkg::*;
  logic clock = 0;
  logic rst = 1;
  logic hrst = 0, req_valid = 0, req_write = 0, req_ready, resp_valid, rdone, pma, q1, q0;
  addr_t req_addr = '0;
  word_t req_wdata = '0, resp_data, got;
  logic qs[8];
  int errors = 0, n_compared = 0, n;
  addr_t addrs[4] = '{9'h000, 9'h1FF, 9'h0AA, 9'h155};
  word_t words[4] = '{16'hA5C3, 16'hFFFF, 16'h0001, 16'h8000};
  reconfig_if link ();
  reconfig_if dead ();
  reconfig_device reconfig_device_i (.clock(clock), .rst(rst), .port(link),
    .hard_reset_pin(hrst), .reset_done(rdone), .pma_reset_out(pma), .stable_clock_quarter(q1));
  // disabled copy: the bench stands in for its requester
  reconfig_device #(.CSP_ENABLE(1'b0)) reconfig_device_off_i (.clock(clock), .rst(rst),
    .port(dead), .hard_reset_pin(1'b0), .reset_done(), .pma_reset_out(),
    .stable_clock_quarter(q0));
  reconfig_requester reconfig_requester_i (.clock(clock), .rst(rst), .port(link),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_ready(req_ready), .resp_valid(resp_valid), .resp_data(resp_data));
  reconfig_port_checker reconfig_port_checker_i (.clock(clock), .rst(rst),
    .reconfig_access_strobe_alias(link.reconfig_access_strobe_alias),
    .reconfig_write_select(link.reconfig_write_select),
    .reconfig_reg_address(link.reconfig_reg_address),
    .reconfig_write_word(link.reconfig_write_word),
    .reconfig_read_word(link.reconfig_read_word),
    .reconfig_done_strobe(link.reconfig_done_strobe),
    .reconfig_port_busy(link.reconfig_port_busy));
  ////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tick(int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task automatic access(logic w, addr_t a, word_t d);
    req_valid = 1; req_write = w; req_addr = a; req_wdata = d; n = 0;
    while (req_ready !== 1'b1) begin
      tick(1); n++;
      if (n > 50) begin errors++; summarize(); end
    end
    tick(1); req_valid = 0; n = 0;
    while (resp_valid !== 1'b1) begin
      tick(1); n++;
      if (n > 20) begin errors++; summarize(); end
    end
    got = resp_data;
  endtask
  task automatic settle;
    n = 0;
    while (pma !== 1'b0 && n < 20) begin tick(1); n++; end
    `CHK("pma released", 1'b0, pma)
    n = 0;
    while (rdone !== 1'b1 && n < 300) begin tick(1); n++; end
    `CHK("reset sequence cycles", `RESET_SEQ_CYCLES, n)
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    forever #4 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    summarize();
  end
  initial begin
    dead.reconfig_access_strobe_alias = 0; dead.reconfig_write_select = 0;
    dead.reconfig_reg_address = 9'h0AA; dead.reconfig_write_word = 16'hFFFF;
    tick(3);
    `CHK("pma in reset", 1'b1, pma)
    `CHK("done flag in reset", 1'b0, rdone)
    rst = 0;
    settle();
    for (int i = 0; i < 4; i++) begin
      access(1'b1, addrs[i], words[i]);
      `CHK("write response", 16'h0000, got)
    end
    for (int i = 0; i < 4; i++) begin
      access(1'b0, addrs[i], 16'h0000);
      `CHK("read word", words[i], got)
    end
    // hard reset mid-run must restart the whole sequence
    hrst = 1; tick(6);
    `CHK("pma on hard reset", 1'b1, pma)
    `CHK("done flag on hard reset", 1'b0, rdone)
    hrst = 0;
    settle();
    access(1'b0, addrs[1], 16'h0000);
    `CHK("read after hard reset", words[1], got)
    // a single-cycle pulse on the pin never reaches the hard reset
    hrst = 1; tick(1);
    hrst = 0; tick(6);
    `CHK("pma ignores pulse", 1'b0, pma)
    `CHK("done flag kept", 1'b1, rdone)
    `CHK("quarter absent when enabled", 1'b0, q1)
    dead.reconfig_access_strobe_alias = 1; tick(1);
    dead.reconfig_access_strobe_alias = 0;
    for (int i = 0; i < 8; i++) begin
      qs[i] = q0;
      `CHK("off done", 1'b0, dead.reconfig_done_strobe)
      `CHK("off read word", 16'h0000, dead.reconfig_read_word)
      if (i >= 2) `CHK("quarter clock", ~qs[i-2], q0)
      tick(1);
    end
    summarize();
  end
endmodule
